// File: rtl/swsel_pkg.sv
// Package for the standby wake and on-to-green SMI event logic: map, fields, types
package swsel_pkg;

  // Bus widths
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int OG_W  = 16;
  localparam int WK_W  = 24;
  localparam int IO_W  = 16;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_OG_EN   = 8'h40;
  localparam logic [7:0] IDX_OG_STAT = 8'h42;
  localparam logic [7:0] IDX_WK_EN   = 8'h44;
  localparam logic [7:0] IDX_WK_STAT = 8'h48;
  localparam logic [7:0] IDX_CTRL    = 8'h50;

  // On-to-green status and enable bit positions
  localparam int OG_SOFT = 12;
  localparam int OG_APM  = 4;
  localparam int OG_RTC  = 3;
  localparam int OG_PWR  = 2;
  localparam int OG_DISP = 1;
  localparam int OG_STBY = 0;

  // Standby wake enable and status bit positions
  localparam int WK_SERIALIZED_IRQ = 20;
  localparam int WK_SMB  = 19;
  localparam int WK_GRPC = 15;
  localparam int WK_PAR  = 12;
  localparam int WK_KBD  = 11;
  localparam int WK_SER  = 10;
  localparam int WK_FLP  = 9;
  localparam int WK_VID  = 8;
  localparam int WK_AUD  = 7;
  localparam int WK_IDE2 = 6;
  localparam int WK_RSV_LSB = 21;
  localparam int WK_RSV_MSB = 23;

  // Implemented bits, reset values and the fixed reserved field
  localparam logic [OG_W-1:0] OG_IMPL        = 16'h101F;
  localparam logic [OG_W-1:0] OG_RESET       = 16'h0000;
  localparam logic [WK_W-1:0] WK_IMPL        = 24'h189FC0;
  localparam logic [WK_W-1:0] WK_EN_RESET    = 24'h200000;
  localparam logic [WK_W-1:0] WK_STAT_RESET  = 24'h000000;
  localparam logic [2:0]      WK_RSV_VAL     = 3'h1;

  // Fixed I/O port decodes
  localparam logic [IO_W-1:0] IO_SOFT_SMI = 16'h00B1;
  localparam logic [IO_W-1:0] IO_KBD_DATA = 16'h0060;
  localparam logic [IO_W-1:0] IO_KBD_CMD  = 16'h0064;
  localparam logic [IO_W-1:0] IO_VID_LO   = 16'h03B0;
  localparam logic [IO_W-1:0] IO_VID_HI   = 16'h03DF;

  // Power-button detection mode field in the control register
  localparam int PB_MODE_LSB = 0;
  localparam int PB_MODE_MSB = 1;
  typedef enum logic [1:0] {PB_FALL, PB_RISE, PB_BOTH, PB_LOW} swsel_pbmode_e;

  // One I/O bus cycle as seen by the decoder
  typedef struct packed {
    logic            valid;
    logic            write;
    logic [IO_W-1:0] addr;
  } swsel_io_s;

  // Range hits from the external I/O range decoders
  typedef struct packed {
    logic grpc;
    logic par;
    logic ser;
    logic flp;
    logic aud;
    logic ide2;
  } swsel_hits_s;

  // Timer expiry pulses
  typedef struct packed {
    logic apm_a;
    logic disp;
    logic stby;
  } swsel_timers_s;

  // Entire state of the block
  typedef struct packed {
    logic [OG_W-1:0]  og_en;
    logic [OG_W-1:0]  og_stat;
    logic [WK_W-1:0]  wk_en;
    logic [WK_W-1:0]  wk_stat;
    swsel_pbmode_e    pb_mode;
    logic             rtc_prev;
    logic             pb_prev;
    logic             ack;
    logic [DAT_W-1:0] rdat;
  } swsel_state_s;

endpackage

// File: rtl/swsel_event_logic.sv
// Standby wake and on-to-green SMI event logic with a classic Wishbone register slave
//
// Behaviour
// [R01] Write to I/O port 0B1h sets soft-SMI status bit 12.
// [R02] APM timer A expiry sets status bit 4.
// [R03] Real-time-clock interrupt assertion sets status bit 3.
// [R04] Power-button event matching programmed mode sets status bit 2.
// [R05] Display timer expiry sets status bit 1.
// [R06] Standby timer expiry sets status bit 0.
// [R07] Wake enable resets to 200000h; bits 23..21 hold 001b.
// [R08] In standby, enabled serialized-IRQ event sets wake bit 20 and SMI.
// [R09] In standby, enabled SMBus event sets wake bit 19 and SMI.
// [R10] In standby, enabled group C access sets wake bit 15 and SMI.
// [R11] In standby, enabled parallel-port access sets wake bit 12 and SMI.
// [R12] In standby, enabled keyboard port 60h/64h cycle sets wake bit 11.
// [R13] In standby, enabled serial-port access sets wake bit 10 and SMI.
// [R14] In standby, enabled floppy access sets wake bit 9 and SMI.
// [R15] In standby, enabled video cycle 3B0h-3DFh sets wake bit 8.
// [R16] In standby, enabled audio access sets wake bit 7 and SMI.
// [R17] In standby, enabled secondary disk access sets wake bit 6.
// [R18] On-to-green events count only when their enable bit is set.
// [R19] Real-time-clock event is a high-to-low edge of the active-low line.
// [R20] Status bits stick until written one; SMI holds while enabled bit set.
// [R21] Reserved on-to-green status bits read zero and ignore writes.
`timescale 1ns/1ps
module swsel_event_logic (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [swsel_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [swsel_pkg::SEL_W-1:0]    wb_sel_i,
  input  wire logic [swsel_pkg::DAT_W-1:0]    wb_dat_i,
  output logic      [swsel_pkg::DAT_W-1:0]    wb_dat_o,
  output logic                                wb_ack_o,
  input  wire swsel_pkg::swsel_io_s           io_cycle_i,
  input  wire swsel_pkg::swsel_hits_s         io_hits_i,
  input  wire swsel_pkg::swsel_timers_s       timers_i,
  input  wire logic                           rtc_irq_n_i,
  input  wire logic                           power_button_n_i,
  input  wire logic                           serialized_irq_event_i,
  input  wire logic                           smbus_event_i,
  input  wire logic                           standby_i,
  output logic                                smi_o
);

  localparam swsel_pkg::swsel_state_s ST_RESET = '{
    og_en:    swsel_pkg::OG_RESET,
    og_stat:  swsel_pkg::OG_RESET,
    wk_en:    swsel_pkg::WK_EN_RESET,
    wk_stat:  swsel_pkg::WK_STAT_RESET,
    pb_mode:  swsel_pkg::PB_FALL,
    rtc_prev: 1'b1,
    pb_prev:  1'b1,
    ack:      1'b0,
    rdat:     '0
  };

  swsel_pkg::swsel_state_s r;
  swsel_pkg::swsel_state_s r_nxt;

  logic                          req;
  logic                          wr;
  logic [swsel_pkg::DAT_W-1:0]   bmask;
  logic [swsel_pkg::DAT_W-1:0]   wbits;
  logic [swsel_pkg::DAT_W-1:0]   rmux;
  logic [swsel_pkg::OG_W-1:0]    og_evt;
  logic [swsel_pkg::WK_W-1:0]    wk_evt;
  logic                          io_wr_soft;
  logic                          io_kbd;
  logic                          io_vid;
  logic                          rtc_fall;
  logic                          pb_fall;
  logic                          pb_rise;
  logic                          pb_evt;

  // Register index hit; the two low address bits are byte lanes
  function automatic logic reg_hit(input logic [swsel_pkg::ADR_W-1:0] adr, input logic [7:0] idx);
    reg_hit = (adr[swsel_pkg::ADR_W-1:2] == idx);
  endfunction

  // Expand byte enables into a bit mask
  function automatic logic [swsel_pkg::DAT_W-1:0] lane_mask(input logic [swsel_pkg::SEL_W-1:0] sel);
    logic [swsel_pkg::DAT_W-1:0] m;
    m = '0;
    for (int i = 0; i < swsel_pkg::SEL_W; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    lane_mask = m;
  endfunction

  // Bus request is taken once; ack follows one cycle later
  assign req   = wb_cyc_i & wb_stb_i & ~r.ack;
  assign wr    = req & wb_we_i;
  assign bmask = lane_mask(wb_sel_i);
  assign wbits = wb_dat_i & bmask;

  // Fixed port decodes on the I/O cycle
  // [R01] soft SMI port
  assign io_wr_soft = io_cycle_i.valid & io_cycle_i.write & (io_cycle_i.addr == swsel_pkg::IO_SOFT_SMI);
  // [R12] keyboard port decode
  assign io_kbd = io_cycle_i.valid &
                  ((io_cycle_i.addr == swsel_pkg::IO_KBD_DATA) | (io_cycle_i.addr == swsel_pkg::IO_KBD_CMD));
  // [R15] video range decode
  assign io_vid = io_cycle_i.valid &
                  (io_cycle_i.addr >= swsel_pkg::IO_VID_LO) & (io_cycle_i.addr <= swsel_pkg::IO_VID_HI);

  // Edge detectors; inputs are synchronous, so no synchroniser is needed
  // [R19] falling edge of the interrupt line
  assign rtc_fall = r.rtc_prev & ~rtc_irq_n_i;
  assign pb_fall  = r.pb_prev & ~power_button_n_i;
  assign pb_rise  = ~r.pb_prev & power_button_n_i;

  // Power-button mode select; low level keeps re-setting while held
  // [R04] mode match
  always_comb begin
    case (r.pb_mode)
      swsel_pkg::PB_FALL: pb_evt = pb_fall;
      swsel_pkg::PB_RISE: pb_evt = pb_rise;
      swsel_pkg::PB_BOTH: pb_evt = pb_fall | pb_rise;
      default:            pb_evt = ~power_button_n_i;
    endcase
  end

  // On-to-green raw event vector
  always_comb begin
    og_evt = '0;
    // [R01] soft SMI event
    og_evt[swsel_pkg::OG_SOFT] = io_wr_soft;
    // [R02] APM timer A
    og_evt[swsel_pkg::OG_APM]  = timers_i.apm_a;
    // [R03] RTC interrupt
    og_evt[swsel_pkg::OG_RTC]  = rtc_fall;
    // [R04] power button
    og_evt[swsel_pkg::OG_PWR]  = pb_evt;
    // [R05] display timer
    og_evt[swsel_pkg::OG_DISP] = timers_i.disp;
    // [R06] standby timer
    og_evt[swsel_pkg::OG_STBY] = timers_i.stby;
  end

  // Standby wake raw event vector
  always_comb begin
    wk_evt = '0;
    // [R08] serialized IRQ
    wk_evt[swsel_pkg::WK_SERIALIZED_IRQ] = serialized_irq_event_i;
    // [R09] SMBus event
    wk_evt[swsel_pkg::WK_SMB]  = smbus_event_i;
    // [R10] group C
    wk_evt[swsel_pkg::WK_GRPC] = io_hits_i.grpc;
    // [R11] parallel port
    wk_evt[swsel_pkg::WK_PAR]  = io_hits_i.par;
    // [R12] keyboard ports
    wk_evt[swsel_pkg::WK_KBD]  = io_kbd;
    // [R13] serial ports
    wk_evt[swsel_pkg::WK_SER]  = io_hits_i.ser;
    // [R14] floppy ports
    wk_evt[swsel_pkg::WK_FLP]  = io_hits_i.flp;
    // [R15] video range
    wk_evt[swsel_pkg::WK_VID]  = io_vid;
    // [R16] audio range
    wk_evt[swsel_pkg::WK_AUD]  = io_hits_i.aud;
    // [R17] secondary disk channel
    wk_evt[swsel_pkg::WK_IDE2] = io_hits_i.ide2;
  end

  // Read mux; unmapped indices read as zero
  always_comb begin
    rmux = '0;
    if (reg_hit(wb_adr_i, swsel_pkg::IDX_OG_EN)) begin
      rmux[swsel_pkg::OG_W-1:0] = r.og_en;
    end else if (reg_hit(wb_adr_i, swsel_pkg::IDX_OG_STAT)) begin
      // [R21] reserved bits read zero
      rmux[swsel_pkg::OG_W-1:0] = r.og_stat & swsel_pkg::OG_IMPL;
    end else if (reg_hit(wb_adr_i, swsel_pkg::IDX_WK_EN)) begin
      rmux[swsel_pkg::WK_W-1:0] = r.wk_en;
    end else if (reg_hit(wb_adr_i, swsel_pkg::IDX_WK_STAT)) begin
      rmux[swsel_pkg::WK_W-1:0] = r.wk_stat;
    end else if (reg_hit(wb_adr_i, swsel_pkg::IDX_CTRL)) begin
      rmux[swsel_pkg::PB_MODE_MSB:swsel_pkg::PB_MODE_LSB] = r.pb_mode;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    logic [swsel_pkg::OG_W-1:0] og_clr;
    logic [swsel_pkg::WK_W-1:0] wk_clr;
    logic [swsel_pkg::WK_W-1:0] wk_wm;
    og_clr = '0;
    wk_clr = '0;
    wk_wm  = '0;
    r_nxt  = r;

    r_nxt.rtc_prev = rtc_irq_n_i;
    r_nxt.pb_prev  = power_button_n_i;
    r_nxt.ack      = req;
    if (req) begin
      r_nxt.rdat = rmux;
    end

    // Register writes; only implemented bits move
    if (wr) begin
      if (reg_hit(wb_adr_i, swsel_pkg::IDX_OG_EN)) begin
        r_nxt.og_en = ((r.og_en & ~bmask[swsel_pkg::OG_W-1:0]) | wbits[swsel_pkg::OG_W-1:0]) &
                      swsel_pkg::OG_IMPL;
      end else if (reg_hit(wb_adr_i, swsel_pkg::IDX_OG_STAT)) begin
        og_clr = wbits[swsel_pkg::OG_W-1:0];
      end else if (reg_hit(wb_adr_i, swsel_pkg::IDX_WK_EN)) begin
        // [R07] reserved top field is never written
        wk_wm = bmask[swsel_pkg::WK_W-1:0] & swsel_pkg::WK_IMPL;
        r_nxt.wk_en = (r.wk_en & ~wk_wm) | (wbits[swsel_pkg::WK_W-1:0] & wk_wm);
      end else if (reg_hit(wb_adr_i, swsel_pkg::IDX_WK_STAT)) begin
        wk_clr = wbits[swsel_pkg::WK_W-1:0];
      end else if (reg_hit(wb_adr_i, swsel_pkg::IDX_CTRL) & bmask[swsel_pkg::PB_MODE_LSB]) begin
        r_nxt.pb_mode = swsel_pkg::swsel_pbmode_e'(wbits[swsel_pkg::PB_MODE_MSB:swsel_pkg::PB_MODE_LSB]);
      end
    end

    // Sticky status; a set in the clearing cycle wins over the clear
    // [R18] only enabled sources set status
    // [R20] write one clears
    // [R21] reserved bits never set
    r_nxt.og_stat = ((r.og_stat & ~og_clr) | (og_evt & r.og_en)) & swsel_pkg::OG_IMPL;
    // [R08] wake sets only in standby with enable
    r_nxt.wk_stat = ((r.wk_stat & ~wk_clr) | (wk_evt & r.wk_en & {swsel_pkg::WK_W{standby_i}})) &
                    swsel_pkg::WK_IMPL;
  end

  // Single state register; reset is synchronous
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= ST_RESET;
    end else begin
      r <= r_nxt;
    end
  end

  // Outputs; SMI stays up as long as any enabled status bit is set
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  // [R20] level SMI request
  assign smi_o = (|(r.og_stat & r.og_en)) | (|(r.wk_stat & r.wk_en & swsel_pkg::WK_IMPL));

  // Checks that watch the state register and the SMI output
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic wr_og_stat;
  logic wr_wk_stat;
  assign wr_og_stat = wr & reg_hit(wb_adr_i, swsel_pkg::IDX_OG_STAT);
  assign wr_wk_stat = wr & reg_hit(wb_adr_i, swsel_pkg::IDX_WK_STAT);

  a_soft_smi_set: assert property ( // [R01]
    io_wr_soft & r.og_en[swsel_pkg::OG_SOFT] |=> r.og_stat[swsel_pkg::OG_SOFT] & smi_o)
    else $error("soft SMI port write did not set status");

  a_apm_timer_set: assert property ( // [R02]
    timers_i.apm_a & r.og_en[swsel_pkg::OG_APM] |=> r.og_stat[swsel_pkg::OG_APM])
    else $error("APM timer expiry did not set status");

  a_rtc_edge_set: assert property ( // [R19]
    $fell(rtc_irq_n_i) & r.og_en[swsel_pkg::OG_RTC] & ~$past(rst_i) |=> r.og_stat[swsel_pkg::OG_RTC])
    else $error("RTC falling edge did not set status");

  a_rtc_level_quiet: assert property ( // [R03]
    ~r.og_stat[swsel_pkg::OG_RTC] & ~rtc_irq_n_i & ~r.rtc_prev |=> ~r.og_stat[swsel_pkg::OG_RTC])
    else $error("RTC low level set status without an edge");

  a_pwr_fall_set: assert property ( // [R04]
    r.pb_mode == swsel_pkg::PB_FALL & r.pb_prev & ~power_button_n_i & r.og_en[swsel_pkg::OG_PWR]
    |=> r.og_stat[swsel_pkg::OG_PWR])
    else $error("power button fall did not set status");

  a_pwr_rise_set: assert property ( // [R04]
    r.pb_mode == swsel_pkg::PB_RISE & ~r.pb_prev & power_button_n_i & r.og_en[swsel_pkg::OG_PWR]
    |=> r.og_stat[swsel_pkg::OG_PWR])
    else $error("power button rise did not set status");

  a_disp_timer_set: assert property ( // [R05]
    timers_i.disp & r.og_en[swsel_pkg::OG_DISP] |=> r.og_stat[swsel_pkg::OG_DISP])
    else $error("display timer expiry did not set status");

  a_stby_timer_set: assert property ( // [R06]
    timers_i.stby & r.og_en[swsel_pkg::OG_STBY] |=> r.og_stat[swsel_pkg::OG_STBY])
    else $error("standby timer expiry did not set status");

  a_og_enable_gate: assert property ( // [R18]
    1'b1 |=> ((r.og_stat & ~$past(r.og_stat) & ~$past(r.og_en)) == '0))
    else $error("disabled on-to-green source set status");

  a_wake_rsv_field: assert property ( // [R07]
    r.wk_en[swsel_pkg::WK_RSV_MSB:swsel_pkg::WK_RSV_LSB] == swsel_pkg::WK_RSV_VAL)
    else $error("wake enable reserved field lost its value");

  a_wake_serialized_irq_set: assert property ( // [R08]
    standby_i & serialized_irq_event_i & r.wk_en[swsel_pkg::WK_SERIALIZED_IRQ] |=> r.wk_stat[swsel_pkg::WK_SERIALIZED_IRQ] & smi_o)
    else $error("serialized IRQ wake not recorded");

  a_wake_smb_set: assert property ( // [R09]
    standby_i & smbus_event_i & r.wk_en[swsel_pkg::WK_SMB] |=> r.wk_stat[swsel_pkg::WK_SMB] & smi_o)
    else $error("SMBus wake not recorded");

  a_wake_kbd_set: assert property ( // [R12]
    standby_i & io_cycle_i.valid & io_cycle_i.addr == swsel_pkg::IO_KBD_CMD & r.wk_en[swsel_pkg::WK_KBD]
    |=> r.wk_stat[swsel_pkg::WK_KBD])
    else $error("keyboard port wake not recorded");

  a_wake_vid_set: assert property ( // [R15]
    standby_i & io_cycle_i.valid & io_cycle_i.addr == swsel_pkg::IO_VID_HI & r.wk_en[swsel_pkg::WK_VID]
    |=> r.wk_stat[swsel_pkg::WK_VID])
    else $error("video range wake not recorded");

  // Just outside the video window must stay quiet; catches an off-by-one compare
  a_vid_range_edge: assert property ( // [R15]
    standby_i & io_cycle_i.valid & ~r.wk_stat[swsel_pkg::WK_VID] &
    ((io_cycle_i.addr < swsel_pkg::IO_VID_LO) | (io_cycle_i.addr > swsel_pkg::IO_VID_HI))
    |=> ~r.wk_stat[swsel_pkg::WK_VID])
    else $error("video wake set outside its range");

  a_wake_needs_stby: assert property ( // [R10]
    ~standby_i |=> ((r.wk_stat & ~$past(r.wk_stat)) == '0)) // [R17]
    else $error("wake status set outside standby");

  a_wake_grpc_set: assert property ( // [R10]
    standby_i & io_hits_i.grpc & r.wk_en[swsel_pkg::WK_GRPC] |=> r.wk_stat[swsel_pkg::WK_GRPC])
    else $error("group C wake not recorded");

  a_wake_par_set: assert property ( // [R11]
    standby_i & io_hits_i.par & r.wk_en[swsel_pkg::WK_PAR] |=> r.wk_stat[swsel_pkg::WK_PAR])
    else $error("parallel port wake not recorded");

  a_wake_ser_set: assert property ( // [R13]
    standby_i & io_hits_i.ser & r.wk_en[swsel_pkg::WK_SER] |=> r.wk_stat[swsel_pkg::WK_SER])
    else $error("serial port wake not recorded");

  a_wake_flp_set: assert property ( // [R14]
    standby_i & io_hits_i.flp & r.wk_en[swsel_pkg::WK_FLP] |=> r.wk_stat[swsel_pkg::WK_FLP])
    else $error("floppy wake not recorded");

  a_wake_aud_set: assert property ( // [R16]
    standby_i & io_hits_i.aud & r.wk_en[swsel_pkg::WK_AUD] |=> r.wk_stat[swsel_pkg::WK_AUD])
    else $error("audio wake not recorded");

  a_wake_ide2_set: assert property ( // [R17]
    standby_i & io_hits_i.ide2 & r.wk_en[swsel_pkg::WK_IDE2] |=> r.wk_stat[swsel_pkg::WK_IDE2])
    else $error("secondary disk wake not recorded");

  a_status_sticky: assert property ( // [R20]
    ~wr_og_stat & ~wr_wk_stat |=> ((r.og_stat & $past(r.og_stat)) == $past(r.og_stat)) &
                                  ((r.wk_stat & $past(r.wk_stat)) == $past(r.wk_stat)))
    else $error("status bit dropped without a clear");

  // The request has no input path, so it may only rise after a register moved
  a_smi_follows: assert property ( // [R20]
    $rose(smi_o) |-> (r.og_stat != $past(r.og_stat)) | (r.wk_stat != $past(r.wk_stat)) |
                     (r.og_en != $past(r.og_en)) | (r.wk_en != $past(r.wk_en)))
    else $error("SMI rose with no status or enable change");

  a_og_stat_clear: assert property ( // [R20]
    wr_og_stat & ((og_evt & r.og_en) == '0) |=> ((r.og_stat & $past(wbits[swsel_pkg::OG_W-1:0])) == '0))
    else $error("write of one did not clear status");

  a_rsv_read_zero: assert property ( // [R21]
    (r.og_stat & ~swsel_pkg::OG_IMPL) == '0 & (r.og_en & ~swsel_pkg::OG_IMPL) == '0)
    else $error("reserved status bit became set");

  a_bus_ack_once: assert property (
    req |=> wb_ack_o ##1 ~wb_ack_o)
    else $error("ack not a single cycle after request");

  c_soft_smi: cover property (io_wr_soft & r.og_en[swsel_pkg::OG_SOFT] ##1 smi_o);
  c_wake_serialized_irq: cover property (standby_i & serialized_irq_event_i & r.wk_en[swsel_pkg::WK_SERIALIZED_IRQ] ##1 smi_o);
  c_status_clear: cover property (smi_o & wr_og_stat ##1 ~smi_o);
  c_set_wins: cover property (wr_og_stat & (og_evt & r.og_en & wbits[swsel_pkg::OG_W-1:0]) != '0);

endmodule

// File: sim/swsel_host_model.sv
// Host-side model that takes the SMI request and counts handler entries
`timescale 1ns/1ps
module swsel_host_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic smi_i,
  output logic      smi_level_o,
  output int        smi_rises_o
);
  // A processor latches the request once per rising edge; a held level is one entry, not many
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smi_level_o <= 1'h0;
      smi_rises_o <= 0;
    end else begin
      smi_level_o <= smi_i;
      if (smi_i && !smi_level_o) begin
        smi_rises_o <= smi_rises_o + 1;
      end
    end
  end
endmodule

// File: sim/swsel_event_logic_tb.sv
// Self-checking bench for the standby wake and on-to-green SMI event logic
`timescale 1ns/1ps
module swsel_event_logic_tb;
  localparam logic [9:0] A_OGEN = {swsel_pkg::IDX_OG_EN, 2'h0};
  localparam logic [9:0] A_OGST = {swsel_pkg::IDX_OG_STAT, 2'h0};
  localparam logic [9:0] A_WKEN = {swsel_pkg::IDX_WK_EN, 2'h0};
  localparam logic [9:0] A_WKST = {swsel_pkg::IDX_WK_STAT, 2'h0};
  localparam logic [9:0] A_CTRL = {swsel_pkg::IDX_CTRL, 2'h0};

  logic                     clk_i = 1'h0;
  logic                     rst_i = 1'h1;
  logic                     cyc   = 1'h0;
  logic                     stb   = 1'h0;
  logic                     we    = 1'h0;
  logic [9:0]               adr   = 10'h0;
  logic [3:0]               sel   = 4'hF;
  logic [31:0]              wdat  = 32'h0;
  logic [31:0]              rdat;
  logic                     ack;
  swsel_pkg::swsel_io_s     io    = '0;
  swsel_pkg::swsel_hits_s   hits  = '0;
  swsel_pkg::swsel_timers_s tmr   = '0;
  logic                     rtc_n = 1'h1;
  logic                     pb_n  = 1'h1;
  logic                     serialized_irq  = 1'h0;
  logic                     smb   = 1'h0;
  logic                     stdby = 1'h0;
  logic                     smi;
  logic                     smi_lvl;
  int                       smi_cnt;
  int                       fail_count = 0;
  int                       checks = 0;
  logic [31:0]              q;

  // Free-running 250 MHz clock
  always #2 clk_i = ~clk_i;

  swsel_event_logic uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .io_cycle_i(io), .io_hits_i(hits), .timers_i(tmr), .rtc_irq_n_i(rtc_n),
    .power_button_n_i(pb_n), .serialized_irq_event_i(serialized_irq), .smbus_event_i(smb),
    .standby_i(stdby), .smi_o(smi)
  );

  swsel_host_model host (
    .clk_i(clk_i), .rst_i(rst_i), .smi_i(smi), .smi_level_o(smi_lvl), .smi_rises_o(smi_cnt)
  );

  task finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; ack and read data are taken at the rising edge that samples ack high
  // A missing ack is left to the hang guard, which fails the run
  task xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
  endtask

  task wr(input logic [9:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task rd(input logic [9:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(q, exp);
  endtask

  // One event source active for exactly one cycle
  task ev(input int k);
    @(posedge clk_i);
    case (k)
      0: tmr.apm_a <= 1'h1;
      1: tmr.disp <= 1'h1;
      2: tmr.stby <= 1'h1;
      3: io <= '{1'h1, 1'h1, 16'h00B1};
      4: rtc_n <= 1'h0;
      5: serialized_irq <= 1'h1;
      6: smb <= 1'h1;
      7: hits.grpc <= 1'h1;
      8: hits.par <= 1'h1;
      9: hits.ser <= 1'h1;
      10: hits.flp <= 1'h1;
      11: hits.aud <= 1'h1;
      12: hits.ide2 <= 1'h1;
      14: io <= '{1'h1, 1'h0, 16'h0060};
      15: io <= '{1'h1, 1'h1, 16'h0064};
      16: io <= '{1'h1, 1'h0, 16'h03B0};
      17: io <= '{1'h1, 1'h1, 16'h03DF};
      18: io <= '{1'h1, 1'h1, 16'h03AF};
      19: io <= '{1'h1, 1'h0, 16'h03E0};
      20: io <= '{1'h1, 1'h0, 16'h00B1};
      default: ;
    endcase
    @(posedge clk_i);
    tmr   <= '0;
    io    <= '0;
    hits  <= '0;
    serialized_irq  <= 1'h0;
    smb   <= 1'h0;
    rtc_n <= 1'h1;
  endtask

  // Event, then status, SMI level and one handler entry, then clear by writing ones
  task tst(input int k, input logic [9:0] a, input logic [31:0] exp);
    int c0;
    c0 = smi_cnt;
    ev(k);
    rd(a, exp);
    chk({31'h0, smi_lvl}, {31'h0, exp != 32'h0});
    chk(smi_cnt - c0, {31'h0, exp != 32'h0});
    wr(a, exp);
    rd(a, 32'h0);
    chk({31'h0, smi_lvl}, 32'h0);
  endtask

  // Hang guard: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test;
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(A_OGEN, 32'h0);
    rd(A_OGST, 32'h0);
    rd(A_WKEN, 32'h200000);
    rd(A_WKST, 32'h0);
    wr(A_WKEN, 32'hFFFFFFFF);
    rd(A_WKEN, 32'h389FC0);
    rd(10'h3FC, 32'h0);
    sel <= 4'h1;
    wr(A_OGEN, 32'hFFFFFFFF);
    sel <= 4'hF;
    rd(A_OGEN, 32'h1F);
    wr(A_OGEN, 32'h101F);
    $display("test registers done");
    tst(0, A_OGST, 32'h10);
    tst(1, A_OGST, 32'h2);
    tst(2, A_OGST, 32'h1);
    tst(3, A_OGST, 32'h1000);
    tst(20, A_OGST, 32'h0);
    tst(4, A_OGST, 32'h8);
    // A line held low gives one event; once cleared it must stay clear
    rtc_n <= 1'h0;
    repeat (2) @(posedge clk_i);
    rd(A_OGST, 32'h8);
    wr(A_OGST, 32'h8);
    rd(A_OGST, 32'h0);
    rtc_n <= 1'h1;
    // Press result tells the rise mode apart from the other three; release is sticky in all modes
    for (int m = 0; m < 4; m++) begin
      wr(A_CTRL, m);
      pb_n <= 1'h0;
      repeat (2) @(posedge clk_i);
      rd(A_OGST, (m != 1) ? 32'h4 : 32'h0);
      pb_n <= 1'h1;
      repeat (2) @(posedge clk_i);
      rd(A_OGST, 32'h4);
      wr(A_OGST, 32'h4);
      rd(A_OGST, 32'h0);
    end
    wr(A_OGEN, 32'h1000);
    tst(0, A_OGST, 32'h0);
    tst(3, A_OGST, 32'h1000);
    wr(A_OGEN, 32'h10);
    ev(0);
    wr(A_OGEN, 32'h0);
    rd(A_OGST, 32'h10);
    chk({31'h0, smi_lvl}, 32'h0);
    wr(A_OGST, 32'hEFE0);
    wr(A_OGEN, 32'h10);
    rd(A_OGST, 32'h10);
    chk({31'h0, smi_lvl}, 32'h1);
    wr(A_OGST, 32'h10);
    rd(A_OGST, 32'h0);
    $display("test on-green done");
    stdby <= 1'h1;
    wr(A_WKEN, 32'h189FC0);
    tst(5, A_WKST, 32'h100000);
    tst(6, A_WKST, 32'h80000);
    tst(7, A_WKST, 32'h8000);
    tst(8, A_WKST, 32'h1000);
    tst(14, A_WKST, 32'h800);
    tst(15, A_WKST, 32'h800);
    tst(9, A_WKST, 32'h400);
    tst(10, A_WKST, 32'h200);
    tst(16, A_WKST, 32'h100);
    tst(17, A_WKST, 32'h100);
    tst(18, A_WKST, 32'h0);
    tst(19, A_WKST, 32'h0);
    tst(11, A_WKST, 32'h80);
    tst(12, A_WKST, 32'h40);
    wr(A_WKEN, 32'h0);
    tst(5, A_WKST, 32'h0);
    wr(A_WKEN, 32'h189FC0);
    stdby <= 1'h0;
    tst(6, A_WKST, 32'h0);
    $display("test standby wake done");
    finish_test;
  end
endmodule
